/* src/ach_pkg.sv */
// constants and types shared by both ends of the converter host link
package ach_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // least conversion time in ns, rounded up to whole cycles
   localparam int CONV_TIME_NS = 8000;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_CNT_W = 10;
   localparam int RESULT_W = 16;
   localparam int BYTE_W = 8;
   localparam int BIT_CNT_W = 5;
   localparam logic [BIT_CNT_W-1:0] BITS_LAST = 5'h0F;
   localparam logic [BIT_CNT_W-1:0] BITS_DONE = 5'h10;
   // device-made serial clock: half period in cycles
   localparam int DEV_HALF_CYC = 4;
   localparam int DIV_W = 3;
   // host-made serial clock: half period in cycles (160 ns period)
   localparam int HOST_HALF_CYC = 8;
   localparam int HOST_CNT_W = 4;
   // host waits for the byte pins to settle through both synchronisers
   localparam int SETTLE_CYC = 8;
   localparam int START_HOLD_CYC = 4;
   // positions in the device input synchroniser
   localparam int SD_CS = 0;
   localparam int SD_RC = 1;
   localparam int SD_BYTE = 2;
   localparam int SD_CSS = 3;
   localparam int SD_PD = 4;
   localparam int SD_REFERENCE_DISABLE = 5;
   localparam int SD_SCLK = 6;
   localparam int SD_TAG = 7;
   localparam int DEV_SYNC_W = 8;
   // positions in the host input synchroniser
   localparam int SH_BUSY = 8;
   localparam int SH_SCLK = 9;
   localparam int SH_SERIAL_DATA_OUT = 10;
   localparam int HOST_SYNC_W = 11;

   typedef enum logic [2:0] {
      ACH_IDLE = 3'b000,
      ACH_START = 3'b001,
      ACH_WAIT_LOW = 3'b010,
      ACH_WAIT_HIGH = 3'b011,
      ACH_READ_HI = 3'b100,
      ACH_READ_LO = 3'b101,
      ACH_SHIFT = 3'b110
   } ach_host_state_e;
endpackage : ach_pkg

/* src/ach_if.sv */
// pin-level link between the converter end and the host end
`timescale 1ns/1ps
interface ach_if;
   logic chip_select_n;
   logic read_convert;
   logic byte_select;
   logic busy;
   logic [7:0] dev_data_o;
   logic dev_data_oe;
   logic [7:0] data_bus;
   logic dev_sclk_o;
   logic dev_sclk_oe;
   logic host_sclk_o;
   logic host_sclk_oe;
   logic serial_clock;
   logic serial_data_out;
   logic serial_data_in;
   logic clock_source_select;
   logic analog_powerdown;
   logic reference_disable;

   // undriven byte pins read as ones, as through pull-ups
   assign data_bus = dev_data_oe ? dev_data_o : 8'hFF;
   assign serial_clock = dev_sclk_oe ? dev_sclk_o : (host_sclk_oe ? host_sclk_o : 1'b0);

   modport dev (
      input chip_select_n, read_convert, byte_select, clock_source_select,
      input analog_powerdown, reference_disable, serial_data_in, serial_clock,
      output busy, dev_data_o, dev_data_oe, dev_sclk_o, dev_sclk_oe, serial_data_out
   );
   modport host (
      output chip_select_n, read_convert, byte_select, clock_source_select,
      output analog_powerdown, reference_disable, serial_data_in,
      output host_sclk_o, host_sclk_oe,
      input busy, data_bus, serial_clock, serial_data_out
   );
endinterface : ach_if

/* src/ach_device.sv */
// converter end: conversion control, byte-wide and serial result output
//
// Operation
// RULE1 - byte select low gives upper byte
// RULE2 - pin n carries bit n or n+8
// RULE3 - lowest pin carries bit 0 or 8
// RULE4 - pins float if deselected or convert low
// RULE5 - convert falling, selected, not busy starts
// RULE6 - read rising while selected drives pins
// RULE7 - select ORed with convert also starts
// RULE8 - internal clock: start sends previous result
// RULE9 - busy low until both registers updated
// RULE10 - clock pin direction follows source select
// RULE11 - serial data follows the serial clock
// RULE12 - chain input used with external clock
// RULE13 - powerdown leaves digital logic running
// RULE14 - reference disable needs external reference
// RULE15 - start while busy low is ignored
// RULE16 - one result word feeds both outputs
`timescale 1ns/1ps
module ach_device
   import ach_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   ach_if.dev pins,
   input wire logic [RESULT_W-1:0] analog_sample,
   output logic sample_taken,
   output logic analog_off,
   output logic reference_off,
   output logic [RESULT_W-1:0] result_word
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [BYTE_W-1:0] byte_pick(input logic [RESULT_W-1:0] word,
                                                   input logic sel);
      byte_pick = sel ? word[BYTE_W-1:0] : word[RESULT_W-1:BYTE_W];
   endfunction : byte_pick

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [DEV_SYNC_W-1:0] sync_a_ff;
   logic [DEV_SYNC_W-1:0] sync_b_ff;
   logic ctrl_prev_ff;
   logic sclk_prev_ff;
   logic cs_n_s;
   logic rc_s;
   logic byte_s;
   logic css_s;
   logic sclk_s;
   logic tag_s;
   logic ctrl_s;
   logic start;
   logic ext_fall;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sync_a_ff <= '0;
         sync_b_ff <= '0;
      end else begin
         sync_a_ff <= {pins.serial_data_in, pins.serial_clock, pins.reference_disable,
                       pins.analog_powerdown, pins.clock_source_select, pins.byte_select,
                       pins.read_convert, pins.chip_select_n};
         sync_b_ff <= sync_a_ff;
      end
   end

   assign cs_n_s = sync_b_ff[SD_CS];
   assign rc_s = sync_b_ff[SD_RC];
   assign byte_s = sync_b_ff[SD_BYTE];
   assign css_s = sync_b_ff[SD_CSS];
   assign sclk_s = sync_b_ff[SD_SCLK];
   assign tag_s = sync_b_ff[SD_TAG];
   // select and convert share one start path
   assign ctrl_s = cs_n_s | rc_s; // RULE7

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         // low like the cleared synchroniser: no false start
         ctrl_prev_ff <= 1'b0;
         sclk_prev_ff <= 1'b0;
      end else begin
         ctrl_prev_ff <= ctrl_s;
         sclk_prev_ff <= sclk_s;
      end
   end

   // ----------------------------------------
   // conversion
   // ----------------------------------------
   logic busy_ff;
   logic [CONV_CNT_W-1:0] conv_cnt_ff;
   logic [RESULT_W-1:0] sample_ff;
   logic [RESULT_W-1:0] result_ff;
   logic sample_taken_ff;
   logic done;

   // a start while busy is low is simply not seen
   assign start = ctrl_prev_ff & ~ctrl_s & busy_ff; // RULE5 RULE7 RULE15
   assign done = ~busy_ff & (conv_cnt_ff == CONV_CNT_W'(CONV_CYCLES - 1));

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         busy_ff <= 1'b1;
         conv_cnt_ff <= '0;
         sample_ff <= '0;
      end else if (start) begin
         busy_ff <= 1'b0; // RULE9
         conv_cnt_ff <= '0;
         sample_ff <= analog_sample;
      end else if (done) begin
         // result, and with external clock the serial shifter, load on this edge; busy rises with them
         busy_ff <= 1'b1; // RULE9
      end else if (!busy_ff) begin
         conv_cnt_ff <= conv_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         result_ff <= '0;
      end else if (done) begin
         result_ff <= sample_ff; // RULE16
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sample_taken_ff <= 1'b0;
      end else begin
         sample_taken_ff <= start;
      end
   end

   // ----------------------------------------
   // parallel output
   // ----------------------------------------
   logic [BYTE_W-1:0] pdata_ff;
   logic pdata_oe_ff;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pdata_ff <= '0;
      end else begin
         pdata_ff <= byte_pick(result_ff, byte_s); // RULE1 RULE2 RULE3
      end
   end

   // enable rises with read going high while selected
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pdata_oe_ff <= 1'b0;
      end else begin
         pdata_oe_ff <= ~cs_n_s & rc_s; // RULE4 RULE6
      end
   end

   // ----------------------------------------
   // serial output
   // ----------------------------------------
   logic [RESULT_W-1:0] shift_ff;
   logic [BIT_CNT_W-1:0] bits_ff;
   logic [DIV_W-1:0] div_ff;
   logic tx_ff;
   logic sclk_o_ff;
   logic tick;

   assign ext_fall = css_s & sclk_prev_ff & ~sclk_s;
   assign tick = tx_ff & (div_ff == DIV_W'(DEV_HALF_CYC - 1));

   // internal clock: divider runs only while a word goes out
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tx_ff <= 1'b0;
         div_ff <= '0;
         sclk_o_ff <= 1'b0;
         bits_ff <= '0;
      end else if (start && !css_s) begin
         tx_ff <= 1'b1; // RULE8
         div_ff <= '0;
         sclk_o_ff <= 1'b0;
         bits_ff <= '0;
      end else if (tick) begin
         div_ff <= '0;
         sclk_o_ff <= ~sclk_o_ff;
         if (sclk_o_ff) begin
            bits_ff <= bits_ff + 1'b1;
            if (bits_ff == BITS_LAST) begin
               tx_ff <= 1'b0;
            end
         end
      end else if (tx_ff) begin
         div_ff <= div_ff + 1'b1;
      end
   end

   // msb first; a bit changes on the falling serial clock edge
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         shift_ff <= '0;
      end else if (start && !css_s) begin
         shift_ff <= result_ff; // RULE8 RULE16
      end else if (done && css_s) begin
         shift_ff <= sample_ff; // RULE9
      end else if (tick && sclk_o_ff) begin
         shift_ff <= {shift_ff[RESULT_W-2:0], 1'b0}; // RULE11
      end else if (ext_fall) begin
         shift_ff <= {shift_ff[RESULT_W-2:0], tag_s}; // RULE11 RULE12
      end
   end

   // ----------------------------------------
   // analog controls
   // ----------------------------------------
   logic analog_off_ff;
   logic reference_off_ff;

   // only analog is switched; every register above keeps running
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         analog_off_ff <= 1'b0;
         reference_off_ff <= 1'b0;
      end else begin
         analog_off_ff <= sync_b_ff[SD_PD]; // RULE13
         reference_off_ff <= sync_b_ff[SD_REFERENCE_DISABLE]; // RULE14
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign pins.busy = busy_ff;
   assign pins.dev_data_o = pdata_ff;
   assign pins.dev_data_oe = pdata_oe_ff;
   assign pins.dev_sclk_o = sclk_o_ff;
   assign pins.dev_sclk_oe = ~css_s; // RULE10
   assign pins.serial_data_out = shift_ff[RESULT_W-1];
   assign sample_taken = sample_taken_ff;
   assign analog_off = analog_off_ff;
   assign reference_off = reference_off_ff;
   assign result_word = result_ff;

endmodule : ach_device

/* src/ach_host.sv */
// host end: starts conversions, reads both bytes, collects serial words
`timescale 1ns/1ps
module ach_host
   import ach_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   ach_if.host pins,
   input wire logic conv_req,
   input wire logic ext_clock_mode,
   input wire logic powerdown_req,
   input wire logic refdis_req,
   input wire logic ext_ref_ok,
   input wire logic [RESULT_W-1:0] tag_word,
   output logic host_idle,
   output logic conv_refused,
   output logic [RESULT_W-1:0] par_result,
   output logic par_valid,
   output logic [RESULT_W-1:0] ser_result,
   output logic ser_valid
);

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   logic [HOST_SYNC_W-1:0] sync_a_ff;
   logic [HOST_SYNC_W-1:0] sync_b_ff;
   logic sclk_prev_ff;
   logic busy_s;
   logic [BYTE_W-1:0] data_s;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sync_a_ff <= '0;
         sync_b_ff <= '0;
         sclk_prev_ff <= 1'b0;
      end else begin
         sync_a_ff <= {pins.serial_data_out, pins.serial_clock, pins.busy, pins.data_bus};
         sync_b_ff <= sync_a_ff;
         sclk_prev_ff <= sync_b_ff[SH_SCLK];
      end
   end

   assign busy_s = sync_b_ff[SH_BUSY];
   assign data_s = sync_b_ff[BYTE_W-1:0];

   // ----------------------------------------
   // control sequence
   // ----------------------------------------
   ach_host_state_e state_ff;
   logic [HOST_CNT_W-1:0] cnt_ff;
   logic cs_n_ff;
   logic rc_ff;
   logic byte_ff;
   logic css_ff;
   logic [BYTE_W-1:0] hi_ff;
   logic [RESULT_W-1:0] par_ff;
   logic par_valid_ff;
   logic refused_ff;
   logic hclk_ff;
   logic [RESULT_W-1:0] tag_ff;
   logic [BIT_CNT_W-1:0] rise_cnt_ff;
   logic hrise;
   logic hfall;
   logic may_start;

   // with the reference off, only an external one allows a start
   assign may_start = busy_s & (~refdis_req | ext_ref_ok); // RULE5 RULE14
   assign hrise = (state_ff == ACH_SHIFT) & ~hclk_ff
                  & (cnt_ff == HOST_CNT_W'(HOST_HALF_CYC - 1));
   assign hfall = (state_ff == ACH_SHIFT) & hclk_ff
                  & (cnt_ff == HOST_CNT_W'(HOST_HALF_CYC - 1));

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_ff <= ACH_IDLE;
         cnt_ff <= '0;
         cs_n_ff <= 1'b1;
         rc_ff <= 1'b1;
         byte_ff <= 1'b0;
         hclk_ff <= 1'b0;
         hi_ff <= '0;
         par_ff <= '0;
         par_valid_ff <= 1'b0;
         refused_ff <= 1'b0;
         rise_cnt_ff <= '0;
      end else begin
         par_valid_ff <= 1'b0;
         refused_ff <= 1'b0;
         case (state_ff)
            ACH_IDLE: begin
               if (conv_req && may_start) begin
                  cs_n_ff <= 1'b0;
                  rc_ff <= 1'b0; // RULE5
                  cnt_ff <= '0;
                  state_ff <= ACH_START;
               end else if (conv_req) begin
                  refused_ff <= 1'b1;
               end
            end
            ACH_START: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == HOST_CNT_W'(START_HOLD_CYC - 1)) begin
                  rc_ff <= 1'b1;
                  state_ff <= ACH_WAIT_LOW;
               end
            end
            ACH_WAIT_LOW: begin
               if (!busy_s) begin
                  state_ff <= ACH_WAIT_HIGH;
               end
            end
            ACH_WAIT_HIGH: begin
               if (busy_s) begin
                  byte_ff <= 1'b0;
                  cnt_ff <= '0;
                  state_ff <= ACH_READ_HI;
               end
            end
            ACH_READ_HI: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == HOST_CNT_W'(SETTLE_CYC - 1)) begin
                  hi_ff <= data_s;
                  byte_ff <= 1'b1;
                  cnt_ff <= '0;
                  state_ff <= ACH_READ_LO;
               end
            end
            ACH_READ_LO: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (cnt_ff == HOST_CNT_W'(SETTLE_CYC - 1)) begin
                  par_ff <= {hi_ff, data_s};
                  par_valid_ff <= 1'b1;
                  cs_n_ff <= 1'b1;
                  byte_ff <= 1'b0;
                  cnt_ff <= '0;
                  rise_cnt_ff <= '0;
                  state_ff <= css_ff ? ACH_SHIFT : ACH_IDLE;
               end
            end
            ACH_SHIFT: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (hrise || hfall) begin
                  cnt_ff <= '0;
                  hclk_ff <= ~hclk_ff; // RULE10
               end
               if (hrise) begin
                  rise_cnt_ff <= rise_cnt_ff + 1'b1;
               end
               if (hfall && rise_cnt_ff == BITS_DONE) begin
                  state_ff <= ACH_IDLE;
               end
            end
            default: begin
               state_ff <= ACH_IDLE;
            end
         endcase
      end
   end

   // mode level only, analog levels pass straight to the pins; mode changes only while idle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         css_ff <= 1'b0;
      end else if (state_ff == ACH_IDLE) begin
         css_ff <= ext_clock_mode;
      end
   end

   // first chain bit stands before any rise; later ones change at rises
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tag_ff <= '0;
      end else if (state_ff == ACH_READ_LO) begin
         tag_ff <= tag_word;
      end else if (hrise && rise_cnt_ff != '0) begin
         tag_ff <= {tag_ff[RESULT_W-2:0], 1'b0}; // RULE12
      end
   end

   // ----------------------------------------
   // serial capture
   // ----------------------------------------
   logic [RESULT_W-1:0] ser_sh_ff;
   logic [BIT_CNT_W-1:0] ser_cnt_ff;
   logic [RESULT_W-1:0] ser_ff;
   logic ser_valid_ff;
   logic take;

   assign take = css_ff ? hrise : (sync_b_ff[SH_SCLK] & ~sclk_prev_ff);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ser_sh_ff <= '0;
         ser_cnt_ff <= '0;
         ser_ff <= '0;
         ser_valid_ff <= 1'b0;
      end else begin
         ser_valid_ff <= 1'b0;
         if (take && ser_cnt_ff != BITS_DONE) begin
            ser_sh_ff <= {ser_sh_ff[RESULT_W-2:0], sync_b_ff[SH_SERIAL_DATA_OUT]}; // RULE11
            ser_cnt_ff <= ser_cnt_ff + 1'b1;
         end else if (ser_cnt_ff == BITS_DONE) begin
            ser_ff <= ser_sh_ff;
            ser_valid_ff <= 1'b1;
            ser_cnt_ff <= '0;
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign pins.chip_select_n = cs_n_ff;
   assign pins.read_convert = rc_ff;
   assign pins.byte_select = byte_ff;
   assign pins.clock_source_select = css_ff;
   assign pins.analog_powerdown = powerdown_req;
   assign pins.reference_disable = refdis_req;
   assign pins.serial_data_in = tag_ff[RESULT_W-1];
   assign pins.host_sclk_o = hclk_ff;
   assign pins.host_sclk_oe = css_ff; // RULE10
   assign host_idle = (state_ff == ACH_IDLE);
   assign conv_refused = refused_ff;
   assign par_result = par_ff;
   assign par_valid = par_valid_ff;
   assign ser_result = ser_ff;
   assign ser_valid = ser_valid_ff;

endmodule : ach_host

/* dv/ach_props.sv */
// concurrent checks on the link between the converter end and the host end
`timescale 1ns/1ps
module ach_props
   import ach_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic chip_select_n,
   input wire logic read_convert,
   input wire logic byte_select,
   input wire logic busy,
   input wire logic [7:0] dev_data_o,
   input wire logic dev_data_oe,
   input wire logic dev_sclk_o,
   input wire logic dev_sclk_oe,
   input wire logic serial_data_out,
   input wire logic clock_source_select,
   input wire logic [RESULT_W-1:0] result_word
);
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic rd_en;
   logic cs_or_rc;
   logic sclk_q_ff;
   int low_cnt_ff;
   int rise_cnt_ff;
   assign rd_en = !chip_select_n && read_convert;
   assign cs_or_rc = chip_select_n | read_convert;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) low_cnt_ff <= 0;
      else if (busy) low_cnt_ff <= 0;
      else low_cnt_ff <= low_cnt_ff + 1;
   end
   always_ff @(posedge clock or posedge reset) begin
      if (reset) sclk_q_ff <= 1'b0;
      else sclk_q_ff <= dev_sclk_o;
   end
   // clock rises per conversion
   always_ff @(posedge clock or posedge reset) begin
      if (reset) rise_cnt_ff <= 0;
      else if (busy) rise_cnt_ff <= 0;
      else if (dev_sclk_o && !sclk_q_ff) rise_cnt_ff <= rise_cnt_ff + 1;
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_busy_span: assert property ($rose(busy) |-> low_cnt_ff == CONV_CYCLES)
      else $error("busy low span wrong");
   a_start_busy: assert property (busy && $fell(cs_or_rc) |-> ##[1:6] !busy)
      else $error("start edge ignored");
   a_start_cause: assert property ($fell(busy) |->
      !$past(cs_or_rc, 3) || !$past(cs_or_rc, 4) || !$past(cs_or_rc, 5))
      else $error("busy fell unasked");
   a_pins_float: assert property (!rd_en && !$past(rd_en, 1) && !$past(rd_en, 2)
      && !$past(rd_en, 3) |-> !dev_data_oe)
      else $error("pins driven unread");
   a_pins_drive: assert property (rd_en && $past(rd_en, 1) && $past(rd_en, 2)
      && $past(rd_en, 3) |-> dev_data_oe)
      else $error("pins idle in read");
   a_byte_map: assert property (dev_data_oe && $past(byte_select, 3) == byte_select
      && $past(result_word, 3) == result_word
      |-> dev_data_o == (byte_select ? result_word[7:0] : result_word[15:8]))
      else $error("wrong byte on pins");
   a_sclk_dir: assert property ($stable(clock_source_select)
      && $past(clock_source_select, 2) == clock_source_select
      && $past(clock_source_select, 3) == clock_source_select
      |-> dev_sclk_oe == !clock_source_select)
      else $error("clock direction wrong");
   a_sclk_idle: assert property (busy && $past(busy, 1) && !clock_source_select
      |-> !dev_sclk_o)
      else $error("clock outside frame");
   a_data_on_low: assert property (!clock_source_select && !busy
      && $changed(serial_data_out) |-> !dev_sclk_o)
      else $error("data moved on high clock");
   a_frame_bits: assert property ($rose(busy) && !clock_source_select
      |-> rise_cnt_ff == 16)
      else $error("frame length wrong");
endmodule : ach_props

/* dv/ach_tb_top.sv */
// self-checking bench joining the converter end and the host end
`timescale 1ns/1ps
module ach_tb_top import ach_pkg::*; ;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic conv_req = 1'b0, ext_mode = 1'b0, pd_req = 1'b0, rd_req = 1'b0, ref_ok = 1'b0;
   logic [RESULT_W-1:0] sample = 16'h0000, tag = 16'h0000, sample_b = 16'h0000;
   logic host_idle, refused, par_valid, ser_valid, analog_off, ref_off, seen;
   logic [RESULT_W-1:0] par_res, ser_res, res_word, bits, tin;
   int rises;
   int n_fail = 0;
   int n_compared = 0;
   ach_if link ();
   ach_if link_b ();
   always #5 clock = ~clock;
   ach_device u_ach_device (.clock(clock), .reset(reset), .pins(link.dev),
      .analog_sample(sample), .sample_taken(), .analog_off(analog_off),
      .reference_off(ref_off), .result_word(res_word));
   ach_host u_ach_host (.clock(clock), .reset(reset), .pins(link.host), .conv_req(conv_req),
      .ext_clock_mode(ext_mode), .powerdown_req(pd_req), .refdis_req(rd_req),
      .ext_ref_ok(ref_ok), .tag_word(tag), .host_idle(host_idle), .conv_refused(refused),
      .par_result(par_res), .par_valid(par_valid), .ser_result(ser_res), .ser_valid(ser_valid));
   // second converter end, driven bare by the bench
   ach_device u_ach_device_b (.clock(clock), .reset(reset), .pins(link_b.dev),
      .analog_sample(sample_b), .sample_taken(), .analog_off(), .reference_off(),
      .result_word());
   ach_props u_ach_props (.clock(clock), .reset(reset), .chip_select_n(link.chip_select_n),
      .read_convert(link.read_convert), .byte_select(link.byte_select), .busy(link.busy),
      .dev_data_o(link.dev_data_o), .dev_data_oe(link.dev_data_oe),
      .dev_sclk_o(link.dev_sclk_o), .dev_sclk_oe(link.dev_sclk_oe),
      .serial_data_out(link.serial_data_out), .clock_source_select(link.clock_source_select),
      .result_word(res_word));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   // one conversion; wire bits at clock rises, chain bits at falls
   task automatic run_conv();
      int i;
      logic sck_q, pv, sv;
      {bits, tin} = '0;
      rises = 0;
      {sck_q, pv, sv} = '0;
      conv_req = 1'b1;
      @(negedge clock) conv_req = 1'b0;
      for (i = 0; i < 3000 && !(pv && host_idle); i++) begin
         @(negedge clock);
         pv = pv | par_valid;
         sv = sv | ser_valid;
         if (link.serial_clock && !sck_q) begin
            bits = {bits[14:0], link.serial_data_out};
            rises++;
         end
         if (!link.serial_clock && sck_q) tin = {tin[14:0], link.serial_data_in};
         sck_q = link.serial_clock;
      end
      seen = pv & sv;
   endtask : run_conv
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_internal();
      sample = 16'hA5C3;
      run_conv();
      check("parallel word", par_res, 16'hA5C3);
      check("held word", res_word, 16'hA5C3);
      check("serial after reset", bits, 16'h0000);
      sample = 16'h3C5A;
      run_conv();
      check("both outputs seen", seen, 1'b1);
      check("parallel word", par_res, 16'h3C5A);
      check("serial word", ser_res, 16'hA5C3);
      check("serial wire", bits, 16'hA5C3);
      check("clock count", rises, 16);
      repeat (SETTLE_CYC) @(negedge clock);
      check("idle byte pins", link.data_bus, 8'hFF);
      check("idle clock", link.serial_clock, 1'b0);
      $display("internal clock test done");
   endtask : t_internal
   task automatic t_external();
      ext_mode = 1'b1;
      tag = 16'h1234;
      sample = 16'hF00F;
      run_conv();
      check("parallel word", par_res, 16'hF00F);
      check("serial word", ser_res, 16'hF00F);
      check("serial wire", bits, 16'hF00F);
      check("chain wire", tin, 16'h1234);
      check("host clocks", rises, 16);
      check("idle clock", link.serial_clock, 1'b0);
      $display("external clock test done");
   endtask : t_external
   task automatic t_power();
      int i;
      logic got = 1'b0;
      ext_mode = 1'b0;
      pd_req = 1'b1;
      rd_req = 1'b1;
      sample = 16'h8001;
      repeat (4) @(negedge clock);
      conv_req = 1'b1;
      @(negedge clock) conv_req = 1'b0;
      for (i = 0; i < 8; i++) begin
         got = got | refused;
         @(negedge clock);
      end
      check("refused", got, 1'b1);
      check("no start", link.busy, 1'b1);
      check("reference off", ref_off, 1'b1);
      check("analog off", analog_off, 1'b1);
      ref_ok = 1'b1;
      run_conv();
      check("powered down word", par_res, 16'h8001);
      check("previous word", ser_res, 16'hF00F);
      pd_req = 1'b0;
      rd_req = 1'b0;
      ref_ok = 1'b0;
      $display("power test done");
   endtask : t_power
   task automatic t_fault();
      int i, low;
      sample_b = 16'h6B2D;
      link_b.read_convert = 1'b0;
      repeat (4) @(negedge clock);
      low = 0;
      for (i = 0; i < 1200; i++) begin
         if (i == 0) link_b.chip_select_n = 1'b0;
         if (i == 4 || i == 204) link_b.read_convert = 1'b1;
         if (i == 200) link_b.read_convert = 1'b0;
         if (i == 10) check("start on select", link_b.busy, 1'b0);
         @(negedge clock);
         if (!link_b.busy) low++;
      end
      check("busy span", low, CONV_CYCLES);
      repeat (SETTLE_CYC) @(negedge clock);
      check("upper byte", link_b.data_bus, 8'h6B);
      link_b.byte_select = 1'b1;
      repeat (SETTLE_CYC) @(negedge clock);
      check("lower byte", link_b.data_bus, 8'h2D);
      link_b.read_convert = 1'b0;
      repeat (SETTLE_CYC) @(negedge clock);
      check("pins float", link_b.data_bus, 8'hFF);
      check("start on convert", link_b.busy, 1'b0);
      link_b.chip_select_n = 1'b1;
      link_b.read_convert = 1'b1;
      $display("fault test done");
   endtask : t_fault
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      link_b.chip_select_n = 1'b1;
      link_b.read_convert = 1'b1;
      {link_b.byte_select, link_b.clock_source_select, link_b.analog_powerdown,
         link_b.reference_disable, link_b.serial_data_in, link_b.host_sclk_o,
         link_b.host_sclk_oe} = '0;
      repeat (6) @(posedge clock);
      @(negedge clock) reset = 1'b0;
      repeat (4) @(negedge clock);
      t_internal();
      t_external();
      t_power();
      t_fault();
      complete_run();
   end
   // about 5000 cycles needed; 20000 allowed
   initial begin
      #200000;
      n_fail++;
      $display("watchdog expired");
      complete_run();
   end
endmodule : ach_tb_top
